//--- rtl/nrg_consts.svh
// Offsets, field positions, codes and timing of the NMT request and guarding block
`ifndef NRG_CONSTS_SVH
`define NRG_CONSTS_SVH
// Register address is {object select[10:8], subindex[7:0]}
`define NRG_OBJ_ASSIGN 3'h0
`define NRG_OBJ_NMT 3'h1
`define NRG_OBJ_GUARD 3'h2
`define NRG_OBJ_DTYPE 3'h3
`define NRG_OBJ_MISC 3'h4
`define NRG_SUB_ALL 8'h80
`define NRG_MISC_CTRL 8'h00
`define NRG_MISC_IRQ_STAT 8'h01
`define NRG_MISC_IRQ_MASK 8'h02
// Highest subindex answers
`define NRG_NMT_MAX_SUB 32'h0000_0080
`define NRG_GUARD_MAX_SUB 32'h0000_0080
`define NRG_DTYPE_MAX_SUB 32'h0000_007F
`define NRG_ASSIGN_MAX_SUB 32'h0000_007F
// Requested and reported states
`define NRG_ST_UNKNOWN 7'h00
`define NRG_ST_MISSING 7'h01
`define NRG_ST_STOP 7'h04
`define NRG_ST_OPER 7'h05
`define NRG_ST_RST_NODE 7'h06
`define NRG_ST_RST_COMM 7'h07
`define NRG_ST_PREOP 7'h7F
// Command specifiers sent on the bus
`define NRG_CS_START 8'h01
`define NRG_CS_STOP 8'h02
`define NRG_CS_PREOP 8'h80
`define NRG_CS_RST_NODE 8'h81
`define NRG_CS_RST_COMM 8'h82
// Slave assignment fields
`define NRG_ASG_SLAVE_BIT 0
`define NRG_ASG_MAND_BIT 3
`define NRG_ASG_RETRY_LSB 8
`define NRG_ASG_IVAL_LSB 16
// Interrupt status bits
`define NRG_IRQ_SENT 0
`define NRG_IRQ_REJECT 1
`define NRG_IRQ_LOST 2
`define NRG_IRQ_MISMATCH 3
`define NRG_IRQ_W 4
// Timing
`define NRG_CLK_NS 40
`define NRG_MS_NS 1000000
`endif

//--- rtl/nrg_pkg.sv
// Types shared by the NMT request and guarding block
package nrg_pkg;
  typedef logic [6:0] nrg_node_t;
  typedef logic [6:0] nrg_state_t;
  typedef logic [10:0] nrg_addr_t;
endpackage

//--- rtl/nrg_ctrl.sv
// NMT request, node guarding and device type check logic of a network master
`timescale 1ns/10ps
`include "nrg_consts.svh"
module nrg_ctrl #(
  parameter int NODES = 128,
  parameter int CYC_PER_MS = `NRG_MS_NS / `NRG_CLK_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire nrg_pkg::nrg_addr_t reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic [NODES-1:0] hb_consumer_set,
  output logic nmt_valid,
  input wire logic nmt_ready,
  output logic [7:0] nmt_cs,
  output nrg_pkg::nrg_node_t nmt_node,
  output logic [NODES-1:0] guard_poll,
  input wire logic ans_valid,
  input wire nrg_pkg::nrg_node_t ans_node,
  input wire nrg_pkg::nrg_state_t ans_state,
  input wire logic dt_req_valid,
  input wire nrg_pkg::nrg_node_t dt_req_node,
  input wire logic [31:0] dt_actual,
  output logic dt_done,
  output nrg_pkg::nrg_node_t dt_node,
  output logic dt_continue,
  output logic irq
);
  import nrg_pkg::*;

  typedef enum logic {NRG_IDLE, NRG_SEND} nrg_phase_e;

  typedef struct packed {
    logic [NODES-1:0][31:0] asg;
    logic [NODES-1:0][31:0] dtype;
    logic [NODES-1:0][6:0] state;
    logic [NODES-1:0] guarded;
    logic [NODES-1:0] failed;
    logic [NODES-1:0] answered;
    logic [NODES-1:0][7:0] miss;
    logic [NODES-1:0][15:0] elapsed;
    logic [NODES-1:0] poll;
    nrg_phase_e phase;
    logic [7:0] cs;
    nrg_node_t node;
    logic master_en;
    logic [`NRG_IRQ_W-1:0] irq_stat;
    logic [`NRG_IRQ_W-1:0] irq_mask;
    logic [31:0] tick_cnt;
    logic [31:0] rdata;
    logic dt_done;
    nrg_node_t dt_node;
    logic dt_cont;
  } nrg_state_s;

  nrg_state_s s_q;
  nrg_state_s s_d;

  // Requested state to command specifier; zero marks an undefined code
  function automatic logic [7:0] cmd_to_cs(input logic [31:0] v);
    case (v)
      32'h0000_0004: cmd_to_cs = `NRG_CS_STOP;
      32'h0000_0005: cmd_to_cs = `NRG_CS_START;
      32'h0000_0006: cmd_to_cs = `NRG_CS_RST_NODE;
      32'h0000_0007: cmd_to_cs = `NRG_CS_RST_COMM;
      32'h0000_007F: cmd_to_cs = `NRG_CS_PREOP;
      default: cmd_to_cs = 8'h00;
    endcase
  endfunction

  // Guarding may run for this node
  function automatic logic guard_ok(input logic [31:0] a, input logic hb, input logic m);
    guard_ok = m && !hb && a[`NRG_ASG_SLAVE_BIT] &&
               (a[`NRG_ASG_RETRY_LSB +: 8] != 8'h00) && (a[`NRG_ASG_IVAL_LSB +: 16] != 16'h0000);
  endfunction

  logic [2:0] sel;
  logic [7:0] sub;
  logic [6:0] sub_node;
  logic ms_tick;
  logic [`NRG_IRQ_W-1:0] ev;
  logic [7:0] wr_cs;
  logic [31:0] expect_dt;

  assign sel = reg_addr[10:8];
  assign sub = reg_addr[7:0];
  assign sub_node = sub[6:0];
  assign ms_tick = (s_q.tick_cnt == 32'(CYC_PER_MS - 1));
  assign wr_cs = cmd_to_cs(reg_wdata);
  assign expect_dt = s_q.dtype[dt_req_node];

  always_comb begin
    s_d = s_q;
    ev = '0;
    s_d.poll = '0;
    s_d.dt_done = 1'b0;
    s_d.rdata = 32'h0000_0000;
    s_d.tick_cnt = ms_tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;

    // Command handed to the bus side, request cleared
    if (s_q.phase == NRG_SEND && nmt_ready) begin
      s_d.phase = NRG_IDLE;
      s_d.cs = 8'h00;
      ev[`NRG_IRQ_SENT] = 1'b1;
    end

    // Guard scheduler, one step per millisecond for every guarded node
    if (ms_tick) begin
      for (int n = 1; n < NODES; n++) begin
        if (s_q.guarded[n]) begin
          if (s_q.elapsed[n] + 16'h0001 >= s_q.asg[n][`NRG_ASG_IVAL_LSB +: 16]) begin
            s_d.elapsed[n] = 16'h0000;
            s_d.poll[n] = 1'b1;
            s_d.answered[n] = 1'b0;
            if (s_q.answered[n]) begin
              s_d.miss[n] = 8'h00;
            end else if (s_q.miss[n] + 8'h01 >= s_q.asg[n][`NRG_ASG_RETRY_LSB +: 8]) begin
              s_d.failed[n] = 1'b1;
              s_d.guarded[n] = 1'b0;
              s_d.poll[n] = 1'b0;
              ev[`NRG_IRQ_LOST] = 1'b1;
            end else begin
              s_d.miss[n] = s_q.miss[n] + 8'h01;
            end
          end else begin
            s_d.elapsed[n] = s_q.elapsed[n] + 16'h0001;
          end
        end
      end
    end

    // Answer from a node refreshes its state
    if (ans_valid) begin
      s_d.answered[ans_node] = 1'b1;
      s_d.failed[ans_node] = 1'b0;
      s_d.state[ans_node] = ans_state;
    end

    // Boot-time device type check
    if (dt_req_valid) begin
      s_d.dt_done = 1'b1;
      s_d.dt_node = dt_req_node;
      s_d.dt_cont = 1'b1;
      if (expect_dt != 32'h0000_0000 && dt_actual != expect_dt) begin
        s_d.dt_cont = 1'b0;
        s_d.state[dt_req_node] = `NRG_ST_PREOP;
        ev[`NRG_IRQ_MISMATCH] = 1'b1;
      end
    end

    // Register writes
    if (reg_we) begin
      case (sel)
        `NRG_OBJ_ASSIGN: begin
          if (sub != 8'h00 && sub < `NRG_SUB_ALL) begin
            s_d.asg[sub_node] = reg_wdata;
          end
        end
        `NRG_OBJ_NMT: begin
          if (sub != 8'h00 && sub <= `NRG_SUB_ALL) begin
            if (wr_cs == 8'h00 || s_q.phase == NRG_SEND) begin
              ev[`NRG_IRQ_REJECT] = 1'b1;
            end else begin
              s_d.phase = NRG_SEND;
              s_d.cs = wr_cs;
              s_d.node = (sub == `NRG_SUB_ALL) ? 7'h00 : sub_node;
            end
          end
        end
        `NRG_OBJ_GUARD: begin
          for (int n = 1; n < NODES; n++) begin
            if ((sub == `NRG_SUB_ALL || sub_node == n[6:0] && !sub[7]) && sub != 8'h00) begin
              if (reg_wdata == 32'h0000_0000) begin
                s_d.guarded[n] = 1'b0;
              end else if (reg_wdata == 32'h0000_0001 &&
                           guard_ok(s_q.asg[n], hb_consumer_set[n], s_q.master_en)) begin
                s_d.guarded[n] = 1'b1;
                s_d.elapsed[n] = 16'h0000;
                s_d.miss[n] = 8'h00;
                s_d.answered[n] = 1'b1;
                s_d.failed[n] = 1'b0;
              end
            end
          end
        end
        `NRG_OBJ_DTYPE: begin
          if (sub != 8'h00 && sub < `NRG_SUB_ALL) begin
            s_d.dtype[sub_node] = reg_wdata;
          end
        end
        `NRG_OBJ_MISC: begin
          case (sub)
            `NRG_MISC_CTRL: s_d.master_en = reg_wdata[0];
            `NRG_MISC_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~reg_wdata[`NRG_IRQ_W-1:0];
            `NRG_MISC_IRQ_MASK: s_d.irq_mask = reg_wdata[`NRG_IRQ_W-1:0];
            default: s_d.master_en = s_q.master_en;
          endcase
        end
        default: s_d.master_en = s_q.master_en;
      endcase
    end
    // New events win over a clear in the same cycle
    s_d.irq_stat = s_d.irq_stat | ev;

    // Register reads, data valid next cycle
    if (reg_re) begin
      case (sel)
        `NRG_OBJ_ASSIGN: begin
          s_d.rdata = (sub == 8'h00) ? `NRG_ASSIGN_MAX_SUB :
                      (sub < `NRG_SUB_ALL) ? s_q.asg[sub_node] : 32'h0000_0000;
        end
        `NRG_OBJ_NMT: begin
          if (sub == 8'h00) begin
            s_d.rdata = `NRG_NMT_MAX_SUB;
          end else if (sub < `NRG_SUB_ALL) begin
            if (s_q.asg[sub_node][`NRG_ASG_SLAVE_BIT] && s_q.failed[sub_node]) begin
              s_d.rdata = {25'h0, `NRG_ST_MISSING};
            end else if (!s_q.asg[sub_node][`NRG_ASG_SLAVE_BIT] || !s_q.guarded[sub_node]) begin
              s_d.rdata = {25'h0, `NRG_ST_UNKNOWN};
            end else begin
              s_d.rdata = {25'h0, s_q.state[sub_node]};
            end
          end
        end
        `NRG_OBJ_GUARD: begin
          if (sub == 8'h00) begin
            s_d.rdata = `NRG_GUARD_MAX_SUB;
          end else if (sub < `NRG_SUB_ALL) begin
            s_d.rdata = {31'h0, s_q.guarded[sub_node]};
          end
        end
        `NRG_OBJ_DTYPE: begin
          s_d.rdata = (sub == 8'h00) ? `NRG_DTYPE_MAX_SUB :
                      (sub < `NRG_SUB_ALL) ? s_q.dtype[sub_node] : 32'h0000_0000;
        end
        `NRG_OBJ_MISC: begin
          case (sub)
            `NRG_MISC_CTRL: s_d.rdata = {31'h0, s_q.master_en};
            `NRG_MISC_IRQ_STAT: s_d.rdata = {28'h0, s_q.irq_stat};
            `NRG_MISC_IRQ_MASK: s_d.rdata = {28'h0, s_q.irq_mask};
            default: s_d.rdata = 32'h0000_0000;
          endcase
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign nmt_valid = (s_q.phase == NRG_SEND);
  assign nmt_cs = s_q.cs;
  assign nmt_node = s_q.node;
  assign guard_poll = s_q.poll;
  assign dt_done = s_q.dt_done;
  assign dt_node = s_q.dt_node;
  assign dt_continue = s_q.dt_cont;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  chk_nmt_sub0 : assert property (@(posedge clk) disable iff (!rst_n)
    reg_re && sel == `NRG_OBJ_NMT && sub == 8'h00 |=> reg_rdata == 32'h0000_0080)
    else $error("NMT subindex 0 did not read 128");

  chk_dtype_sub0 : assert property (@(posedge clk) disable iff (!rst_n)
    reg_re && sel == `NRG_OBJ_DTYPE && sub == 8'h00 |=> reg_rdata == 32'h0000_007F)
    else $error("Device type subindex 0 did not read 127");

  chk_bad_cmd : assert property (@(posedge clk) disable iff (!rst_n)
    reg_we && sel == `NRG_OBJ_NMT && wr_cs == 8'h00 && !nmt_valid |=> !nmt_valid)
    else $error("Undefined NMT code started a command");

  chk_all_nodes : assert property (@(posedge clk) disable iff (!rst_n)
    reg_we && sel == `NRG_OBJ_NMT && sub == 8'h80 && wr_cs != 8'h00 && !nmt_valid
    |=> nmt_valid && nmt_node == 7'h00)
    else $error("Subindex 128 request not sent to all nodes");

  chk_start_code : assert property (@(posedge clk) disable iff (!rst_n)
    reg_we && sel == `NRG_OBJ_NMT && sub == 8'h05 && reg_wdata == 32'h0000_0005 && !nmt_valid
    |=> nmt_cs == 8'h01 ##0 nmt_node == 7'h05)
    else $error("Start request gave wrong command");

  chk_req_clear : assert property (@(posedge clk) disable iff (!rst_n)
    nmt_valid && nmt_ready |=> !nmt_valid && nmt_cs == 8'h00)
    else $error("Request data not cleared after send");

  chk_guard_master : assert property (@(posedge clk) disable iff (!rst_n)
    reg_we && sel == `NRG_OBJ_GUARD && !s_q.master_en && reg_wdata == 32'h0000_0001
    |=> (s_q.guarded & ~$past(s_q.guarded)) == '0)
    else $error("Guarding started outside master mode");

  chk_guard_read : assert property (@(posedge clk) disable iff (!rst_n)
    reg_re && sel == `NRG_OBJ_GUARD && sub == 8'h05 && !reg_we
    |=> reg_rdata == {31'h0, $past(s_q.guarded[5])})
    else $error("Guard read does not match guarded state");

  chk_type_mismatch : assert property (@(posedge clk) disable iff (!rst_n)
    dt_req_valid && expect_dt != 32'h0000_0000 && dt_actual != expect_dt
    |=> dt_done && !dt_continue && s_q.state[$past(dt_req_node)] == 7'h7F)
    else $error("Type mismatch did not hold node pre-operational");

  chk_type_zero : assert property (@(posedge clk) disable iff (!rst_n)
    dt_req_valid && expect_dt == 32'h0000_0000 |=> dt_done && dt_continue)
    else $error("Zero expected type blocked boot");

  // Register views, guarding limits and the device type match
  chk_unknown_read : assert property (@(posedge clk) disable iff (!rst_n)
    reg_re && sel == `NRG_OBJ_NMT && sub == 8'h05 && !s_q.guarded[5] && !s_q.failed[5]
    |=> reg_rdata == 32'h0000_0000)
    else $error("Unmonitored node did not read state 0");

  chk_missing_read : assert property (@(posedge clk) disable iff (!rst_n)
    reg_re && sel == `NRG_OBJ_NMT && sub == 8'h05 && s_q.asg[5][`NRG_ASG_SLAVE_BIT] &&
    s_q.failed[5] |=> reg_rdata == 32'h0000_0001)
    else $error("Failed node did not read state 1");

  chk_guard_wo : assert property (@(posedge clk) disable iff (!rst_n)
    reg_re && sel == `NRG_OBJ_GUARD && sub == `NRG_SUB_ALL |=> reg_rdata == 32'h0000_0000)
    else $error("Guard subindex 128 was readable");

  chk_hb_blocks : assert property (@(posedge clk) disable iff (!rst_n)
    reg_we && sel == `NRG_OBJ_GUARD && sub == 8'h06 && hb_consumer_set[6] && !s_q.guarded[6]
    |=> !s_q.guarded[6])
    else $error("Guarding started beside a heartbeat consumer");

  chk_guard_zero : assert property (@(posedge clk) disable iff (!rst_n)
    reg_we && sel == `NRG_OBJ_GUARD && sub == 8'h09 && !s_q.guarded[9] &&
    (s_q.asg[9][`NRG_ASG_RETRY_LSB +: 8] == 8'h00 ||
     s_q.asg[9][`NRG_ASG_IVAL_LSB +: 16] == 16'h0000) |=> !s_q.guarded[9])
    else $error("Guarding started with a zero retry or interval");

  chk_poll_guarded : assert property (@(posedge clk) disable iff (!rst_n)
    guard_poll != '0 |-> (guard_poll & ~$past(s_q.guarded)) == '0)
    else $error("Guard poll sent to an unguarded node");

  chk_lost_count : assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_q.failed[5]) |-> $past(s_q.miss[5]) + 8'h01 == s_q.asg[5][`NRG_ASG_RETRY_LSB +: 8])
    else $error("Node lost after the wrong number of polls");

  chk_type_match : assert property (@(posedge clk) disable iff (!rst_n)
    dt_req_valid && expect_dt != 32'h0000_0000 && dt_actual == expect_dt |=> dt_done && dt_continue)
    else $error("Matching type did not continue boot");

endmodule // nrg_ctrl

//--- verification/nrg_slave_model.sv
// Slave node model: takes NMT commands and answers guard polls
`timescale 1ns/10ps
`include "nrg_consts.svh"
module nrg_slave_model #(
  parameter int NODES = 128
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nmt_valid,
  output logic nmt_ready,
  input wire logic [7:0] nmt_cs,
  input wire nrg_pkg::nrg_node_t nmt_node,
  input wire logic [NODES-1:0] guard_poll,
  output logic ans_valid,
  output nrg_pkg::nrg_node_t ans_node,
  output nrg_pkg::nrg_state_t ans_state,
  input wire logic mute
);
  import nrg_pkg::*;
  nrg_state_t st [NODES];
  initial begin
    nmt_ready = 1'b0;
    ans_valid = 1'b0;
    ans_node = '0;
    ans_state = '0;
    foreach (st[i]) st[i] = `NRG_ST_PREOP;
  end
  always @(posedge clk) begin
    ans_valid <= 1'b0;
    // Idle answer lines toggle so stale values never pass
    ans_node <= ~ans_node;
    ans_state <= ~ans_state;
    if (!rst_n) begin
      nmt_ready <= 1'b0;
    end else if (nmt_valid && nmt_ready) begin
      nmt_ready <= 1'b0;
      for (int i = 0; i < NODES; i++) begin
        if (nmt_node == 7'h00 || nmt_node == i) begin
          st[i] <= (nmt_cs == `NRG_CS_START) ? `NRG_ST_OPER :
                   (nmt_cs == `NRG_CS_STOP) ? `NRG_ST_STOP : `NRG_ST_PREOP;
        end
      end
    end else if (nmt_valid) begin
      // Prompt or slow acceptance
      nmt_ready <= ($urandom_range(2, 0) == 0);
    end
    for (int i = 1; i < NODES; i++) begin
      if (guard_poll[i] && !mute) begin
        ans_valid <= 1'b1;
        ans_node <= nrg_node_t'(i);
        ans_state <= st[i];
      end
    end
  end
endmodule // nrg_slave_model

//--- verification/nrg_ctrl_tb.sv
// Self-checking bench of the NMT request and guarding logic
`timescale 1ns/10ps
`include "nrg_consts.svh"
module nrg_ctrl_tb;
  import nrg_pkg::*;
  localparam int N = 128;
  localparam logic [2:0] OA = `NRG_OBJ_ASSIGN;
  localparam logic [2:0] ON = `NRG_OBJ_NMT;
  localparam logic [2:0] OG = `NRG_OBJ_GUARD;
  localparam logic [2:0] OD = `NRG_OBJ_DTYPE;
  localparam logic [2:0] OM = `NRG_OBJ_MISC;
  localparam logic [31:0] CODES [5] = '{32'h4, 32'h6, 32'h7, 32'h7F, 32'h5};
  localparam logic [7:0] CSS [5] = '{`NRG_CS_STOP, `NRG_CS_RST_NODE, `NRG_CS_RST_COMM,
    `NRG_CS_PREOP, `NRG_CS_START};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  nrg_addr_t reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic [N-1:0] hb = '0;
  logic nmt_valid, nmt_ready, ans_valid, dt_done, dt_continue, irq;
  logic [7:0] nmt_cs;
  nrg_node_t nmt_node, ans_node, dt_node;
  nrg_state_t ans_state;
  logic [N-1:0] guard_poll;
  logic dt_req_valid = 1'b0;
  nrg_node_t dt_req_node = '0;
  logic [31:0] dt_actual = '0;
  logic mute = 1'b0;
  logic rd_was = 1'b0;
  logic [31:0] r;
  logic [31:0] q_rd [$];
  logic [14:0] q_nmt [$];
  logic [7:0] q_dt [$];
  int err_total = 0;
  int samples_checked = 0;

  nrg_ctrl #(.NODES(N), .CYC_PER_MS(10)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .hb_consumer_set(hb), .nmt_valid(nmt_valid), .nmt_ready(nmt_ready), .nmt_cs(nmt_cs),
    .nmt_node(nmt_node), .guard_poll(guard_poll), .ans_valid(ans_valid), .ans_node(ans_node),
    .ans_state(ans_state), .dt_req_valid(dt_req_valid), .dt_req_node(dt_req_node),
    .dt_actual(dt_actual), .dt_done(dt_done), .dt_node(dt_node), .dt_continue(dt_continue),
    .irq(irq));
  nrg_slave_model #(.NODES(N)) slave (.clk(clk), .rst_n(rst_n), .nmt_valid(nmt_valid),
    .nmt_ready(nmt_ready), .nmt_cs(nmt_cs), .nmt_node(nmt_node), .guard_poll(guard_poll),
    .ans_valid(ans_valid), .ans_node(ans_node), .ans_state(ans_state), .mute(mute));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Results are compared against the oldest note
  always @(posedge clk) begin
    if (rd_was === 1'b1) chk(q_rd.size() > 0 && reg_rdata === q_rd.pop_front(), "read data");
    if ((nmt_valid && nmt_ready) === 1'b1)
      chk(q_nmt.size() > 0 && {nmt_cs, nmt_node} === q_nmt.pop_front(), "command");
    if (|guard_poll === 1'b1) chk(guard_poll === (N'(1) << 5), "poll to unguarded node");
    if (dt_done === 1'b1)
      chk(q_dt.size() > 0 && {dt_continue, dt_node} === q_dt.pop_front(), "type check");
    rd_was = reg_re;
  end

  task automatic wr(input logic [2:0] o, input logic [7:0] s, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= {o, s};
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] o, input logic [7:0] s, input logic [31:0] e);
    q_rd.push_back(e);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= {o, s};
    @(posedge clk);
    reg_re <= 1'b0;
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk);
      if (q_rd.size() + q_nmt.size() + q_dt.size() == 0) break;
    end
    if (i == 60) begin
      chk(1'b0, "result missing");
      summarize();
    end
  endtask
  task automatic req(input logic [7:0] s, input logic [31:0] v, input logic [7:0] cs);
    q_nmt.push_back({cs, (s == `NRG_SUB_ALL) ? 7'h00 : s[6:0]});
    wr(ON, s, v);
    drain();
    chk(nmt_valid === 1'b0 && nmt_cs === 8'h00, "request data kept");
  endtask
  task automatic dtc(input logic [6:0] n, input logic [31:0] e, a, input logic c);
    wr(OD, {1'b0, n}, e);
    q_dt.push_back({c, n});
    @(posedge clk);
    dt_req_valid <= 1'b1;
    dt_req_node <= n;
    dt_actual <= a;
    @(posedge clk);
    dt_req_valid <= 1'b0;
    dt_actual <= ~a;
    drain();
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    chk(1'b0, "run too long");
    summarize();
  end

  initial begin
    void'($urandom(32'h97763A7F));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    hb[6] <= 1'b1;
    rd(ON, 8'h00, `NRG_NMT_MAX_SUB);
    rd(OG, 8'h00, `NRG_GUARD_MAX_SUB);
    rd(OG, `NRG_SUB_ALL, 32'h0);
    rd(OD, 8'h00, `NRG_DTYPE_MAX_SUB);
    rd(3'h7, 8'h33, 32'h0);
    rd(ON, 8'h05, 32'h0);
    req(`NRG_SUB_ALL, 32'h7F, `NRG_CS_PREOP);
    for (int k = 0; k < 5; k++) req(8'h05, CODES[k], CSS[k]);
    chk(irq === 1'b0, "masked irq");
    wr(OM, `NRG_MISC_IRQ_MASK, 32'hF);
    repeat (2) @(negedge clk);
    chk(irq === 1'b1, "irq low");
    wr(ON, 8'h05, 32'h3);
    rd(OM, `NRG_MISC_IRQ_STAT, 32'h3);
    chk(nmt_valid === 1'b0, "bad code sent");
    wr(OM, `NRG_MISC_IRQ_STAT, 32'h3);
    rd(OM, `NRG_MISC_IRQ_STAT, 32'h0);
    drain();
    chk(irq === 1'b0, "irq stuck");
    // Interval 2 ms, retry factor 3
    wr(OA, 8'h05, 32'h0002_0301);
    wr(OG, 8'h05, 32'h1);
    rd(OG, 8'h05, 32'h0);
    wr(OM, `NRG_MISC_CTRL, 32'h1);
    wr(OA, 8'h06, 32'h0002_0301);
    wr(OA, 8'h09, 32'h0002_0001);
    wr(OG, 8'h06, 32'h1);
    wr(OG, 8'h09, 32'h1);
    wr(OG, 8'h05, 32'h1);
    rd(OG, 8'h06, 32'h0);
    rd(OG, 8'h09, 32'h0);
    rd(OG, 8'h05, 32'h1);
    repeat (45) @(posedge clk);
    rd(ON, 8'h05, 32'h5);
    req(8'h05, 32'h4, `NRG_CS_STOP);
    repeat (45) @(posedge clk);
    rd(ON, 8'h05, 32'h4);
    mute <= 1'b1;
    repeat (54) @(posedge clk);
    rd(OG, 8'h05, 32'h1);
    repeat (44) @(posedge clk);
    rd(OG, 8'h05, 32'h0);
    rd(ON, 8'h05, 32'h1);
    mute <= 1'b0;
    wr(OG, 8'h05, 32'h1);
    rd(OG, 8'h05, 32'h1);
    wr(OG, `NRG_SUB_ALL, 32'h0);
    rd(OG, 8'h05, 32'h0);
    r = $urandom | 32'h1;
    dtc(7'h07, r, r, 1'b1);
    dtc(7'h07, r, r ^ 32'h100, 1'b0);
    dtc(7'h08, 32'h0, r, 1'b1);
    drain();
    summarize();
  end
endmodule // nrg_ctrl_tb
